// file: hdl/ssio_pkg.sv
// Shared constants, types and layouts of the two-channel synchronous serial port
// Functional notes
// - Two independent channels, interrupts fifteen and seventeen
// - Per-channel counter tracks shifted bits
// - Exactly eight bits, unframed, full duplex
// - Start bit one starts transfer
// - Halt bit aborts and holds stopped
// - Busy bit reads one during transfer
// - Done flag set at end, zero-write clears
// - Interrupt equals done flag and enable
// - Data access (in data-access activation mode), reset or halt clear done
// - Clock select divides prescaler or picks pin
// - Internal shift clock has even duty
// - Clock drive enable forces clock pin
// - Data drive enable forces output pin
// - Bit order select: LSB or MSB first
// - Activation select: start bit or data access
// - Control bits seven to four unused
// - Data register byte is shifted out
// - Received bits assemble into data register
package ssio_pkg;

	// ---------------------------------------------------------------
	// Channels
	// ---------------------------------------------------------------
	localparam int         NCH         = 2;
	localparam int         IRQ_NUM_CH1 = 15;
	localparam int         IRQ_NUM_CH2 = 17;

	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [3:0] REG_STRIDE  = 4'h8;
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_DATA    = 4'h4;

	// ---------------------------------------------------------------
	// Control word bit positions
	// ---------------------------------------------------------------
	localparam int         B_CLK_OE    = 0;
	localparam int         B_DATA_OE   = 1;
	localparam int         B_ORDER     = 2;
	localparam int         B_MODE      = 3;
	localparam int         B_BEGIN     = 8;
	localparam int         B_HALT      = 9;
	localparam int         B_BUSY      = 10;
	localparam int         B_DONE      = 11;
	localparam int         B_IE        = 12;
	localparam int         B_SEL_LO    = 13;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] CTRL_HI_RST = 8'h02;
	localparam logic [7:0] CTRL_LO_RST = 8'h00;
	localparam logic [7:0] DATA_RST    = 8'h00;

	// ---------------------------------------------------------------
	// Shift clock selection and half periods in prescaler ticks
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		SSIO_DIV2  = 3'h0,
		SSIO_DIV4  = 3'h1,
		SSIO_DIV16 = 3'h2,
		SSIO_DIV32 = 3'h3,
		SSIO_DIV64 = 3'h4,
		SSIO_EXT   = 3'h5,
		SSIO_BAD6  = 3'h6,
		SSIO_BAD7  = 3'h7
	} ssio_clksel_e;

	localparam logic [5:0] HALF_DIV2   = 6'h01;
	localparam logic [5:0] HALF_DIV4   = 6'h02;
	localparam logic [5:0] HALF_DIV16  = 6'h08;
	localparam logic [5:0] HALF_DIV32  = 6'h10;
	localparam logic [5:0] HALF_DIV64  = 6'h20;
	localparam logic [3:0] BITS_LAST   = 4'h7;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef struct packed {
		ssio_clksel_e clk_sel;
		logic         ie;
		logic         halt;
		logic         mode;
		logic         order;
		logic         data_oe;
		logic         clk_oe;
	} ssio_cfg_s;

	typedef struct packed {
		logic sot;
		logic sot_oe;
		logic sck;
		logic sck_oe;
	} ssio_pin_s;

	typedef enum logic [1:0] {
		SSIO_IDLE = 2'b01,
		SSIO_RUN  = 2'b10
	} ssio_state_e;

endpackage : ssio_pkg

// file: hdl/ssio_sck_gen.sv
// Shift clock generator: internal divider or synchronised clock pin
`timescale 1ns/100ps
module ssio_sck_gen (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  presc_tick,
	input  wire ssio_pkg::ssio_clksel_e clk_sel,
	input  wire logic                  run,
	input  wire logic                  sck_pin,
	output logic                       sck_level,
	output logic                       sck_fall,
	output logic                       sck_rise
);
	import ssio_pkg::*;

	logic [5:0] half;
	logic [5:0] cnt;
	logic       int_sck;
	logic       int_wrap;
	logic       pin_s1;
	logic       pin_s2;
	logic       pin_prev;
	logic       ext;

	// ---------------------------------------------------------------
	// Internal divider
	// ---------------------------------------------------------------
	always_comb begin
		case (clk_sel)
			SSIO_DIV2:  half = HALF_DIV2;
			SSIO_DIV4:  half = HALF_DIV4;
			SSIO_DIV16: half = HALF_DIV16;
			SSIO_DIV32: half = HALF_DIV32;
			SSIO_DIV64: half = HALF_DIV64;
			default:    half = HALF_DIV2;
		endcase
	end

	assign int_wrap = run && presc_tick && (cnt == half - 6'h01);

	// Equal tick counts high and low
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt     <= 6'h00;
			int_sck <= 1'b1;
		end else if (!run) begin
			cnt     <= 6'h00;
			int_sck <= 1'b1;
		end else if (int_wrap) begin
			cnt     <= 6'h00;
			int_sck <= ~int_sck;
		end else if (presc_tick) begin
			cnt     <= cnt + 6'h01;
		end
	end

	// ---------------------------------------------------------------
	// Clock pin synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1   <= 1'b1;
			pin_s2   <= 1'b1;
			pin_prev <= 1'b1;
		end else begin
			pin_s1   <= sck_pin;
			pin_s2   <= pin_s1;
			pin_prev <= pin_s2;
		end
	end

	// ---------------------------------------------------------------
	// Selection
	// ---------------------------------------------------------------
	assign ext       = (clk_sel == SSIO_EXT);
	assign sck_level = ext ? pin_s2 : int_sck;
	assign sck_fall  = run && (ext ? (pin_prev && !pin_s2) : (int_wrap && int_sck));
	assign sck_rise  = run && (ext ? (!pin_prev && pin_s2) : (int_wrap && !int_sck));

endmodule : ssio_sck_gen

// file: hdl/ssio_top.sv
// Two-channel synchronous serial port with Avalon-MM register access
//
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
module ssio_top #(
	parameter int NCH = ssio_pkg::NCH
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic [3:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	input  wire logic [3:0]       avs_byteenable,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	input  wire logic             presc_tick,
	input  wire logic [NCH-1:0]   serial_in,
	input  wire logic [NCH-1:0]   shift_clock_in,
	output ssio_pkg::ssio_pin_s [NCH-1:0] pins,
	output logic      [NCH-1:0]   irq
);
	import ssio_pkg::*;

	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic rst_ff;
	logic rst_n;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_ff <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_ff <= 1'b1;
			rst_n  <= rst_ff;
		end
	end

	// ---------------------------------------------------------------
	// Bus handshake
	// ---------------------------------------------------------------
	logic        ack;
	logic        req;
	logic        wr_go;
	logic        rd_go;
	logic        lo_we;
	logic        hi_we;
	logic [15:0] ctrl_rd [NCH];
	logic [7:0]  data_rd [NCH];
	logic [31:0] next_readdata;

	assign req             = avs_read || avs_write;
	assign avs_waitrequest = req && !ack;
	assign wr_go           = avs_write && ack;
	assign rd_go           = avs_read && ack;
	assign lo_we           = avs_byteenable[0];
	assign hi_we           = avs_byteenable[1];

	// One wait state, then the access completes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
		end else begin
			ack <= req && !ack;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		for (int c = 0; c < NCH; c++) begin
			if (avs_address == 4'(c * REG_STRIDE + REG_CTRL)) begin
				next_readdata = {16'h0000, ctrl_rd[c]};
			end
			if (avs_address == 4'(c * REG_STRIDE + REG_DATA)) begin
				next_readdata = {24'h00_0000, data_rd[c]};
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ack) begin
			avs_readdata <= next_readdata;
		end
	end

	// ---------------------------------------------------------------
	// Channels
	// ---------------------------------------------------------------
	for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
		ssio_cfg_s   cfg;
		ssio_state_e state;
		logic        done;
		logic [7:0]  data;
		logic [7:0]  data_now;
		logic [3:0]  bits;
		logic        sot;
		logic        sin_s1;
		logic        sin_s2;
		logic        sck_lvl;
		logic        sck_fall;
		logic        sck_rise;
		logic        ctl_hit;
		logic        dat_hit;
		logic        ctl_hi_wr;
		logic        ctl_lo_wr;
		logic        dat_wr;
		logic        dat_acc;
		logic        new_halt;
		logic        start;
		logic        finish;
		logic        running;

		assign ctl_hit   = (avs_address == 4'(ch * REG_STRIDE + REG_CTRL));
		assign dat_hit   = (avs_address == 4'(ch * REG_STRIDE + REG_DATA));
		assign ctl_hi_wr = wr_go && ctl_hit && hi_we;
		assign ctl_lo_wr = wr_go && ctl_hit && lo_we;
		assign dat_wr    = wr_go && dat_hit && lo_we && !running;
		assign dat_acc   = (wr_go || rd_go) && dat_hit && !running;
		assign running   = (state == SSIO_RUN);
		assign new_halt  = ctl_hi_wr ? avs_writedata[B_HALT] : cfg.halt;
		assign data_now  = dat_wr ? avs_writedata[7:0] : data;

		// Start by the start bit or by a data access
		assign start = !running && !new_halt &&
			((ctl_hi_wr && avs_writedata[B_BEGIN] && !cfg.mode) ||
			 (dat_acc && cfg.mode));
		assign finish = running && !new_halt && sck_rise && (bits == BITS_LAST);

		// -----------------------------------------------------------
		// Configuration
		// -----------------------------------------------------------
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				cfg.clk_sel <= ssio_clksel_e'(CTRL_HI_RST[7:5]);
				cfg.ie      <= CTRL_HI_RST[4];
				cfg.halt    <= CTRL_HI_RST[1];
				cfg.mode    <= CTRL_LO_RST[3];
				cfg.order   <= CTRL_LO_RST[2];
				cfg.data_oe <= CTRL_LO_RST[1];
				cfg.clk_oe  <= CTRL_LO_RST[0];
			end else begin
				if (ctl_hi_wr) begin
					cfg.clk_sel <= ssio_clksel_e'(avs_writedata[B_SEL_LO +: 3]);
					cfg.ie      <= avs_writedata[B_IE];
					cfg.halt    <= avs_writedata[B_HALT];
				end
				if (ctl_lo_wr) begin
					cfg.mode    <= avs_writedata[B_MODE];
					cfg.order   <= avs_writedata[B_ORDER];
					cfg.data_oe <= avs_writedata[B_DATA_OE];
					cfg.clk_oe  <= avs_writedata[B_CLK_OE];
				end
			end
		end

		// -----------------------------------------------------------
		// Transfer state
		// -----------------------------------------------------------
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				state <= SSIO_IDLE;
			end else begin
				case (state)
					SSIO_IDLE: begin
						if (start) begin
							state <= SSIO_RUN;
						end
					end
					SSIO_RUN: begin
						if (new_halt) begin
							state <= SSIO_IDLE;
						end else if (finish) begin
							state <= SSIO_IDLE;
						end
					end
					default: begin
						state <= SSIO_IDLE;
					end
				endcase
			end
		end

		// -----------------------------------------------------------
		// Bit counter
		// -----------------------------------------------------------
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				bits <= 4'h0;
			end else if (start) begin
				bits <= 4'h0;
			end else if (running && sck_rise) begin
				bits <= bits + 4'h1;
			end
		end

		// -----------------------------------------------------------
		// Shift data register
		// -----------------------------------------------------------
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				data <= DATA_RST;
			end else if (dat_wr) begin
				data <= avs_writedata[7:0];
			end else if (running && !new_halt && sck_rise) begin
				if (cfg.order) begin
					data <= {data[6:0], sin_s2};
				end else begin
					data <= {sin_s2, data[7:1]};
				end
			end
		end

		// -----------------------------------------------------------
		// Output bit changes on start and on falling edges
		// -----------------------------------------------------------
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				sot <= 1'b1;
			end else if (start) begin
				sot <= cfg.order ? data_now[7] : data_now[0];
			end else if (running && sck_fall) begin
				sot <= cfg.order ? data[7] : data[0];
			end
		end

		// -----------------------------------------------------------
		// Serial input synchroniser
		// -----------------------------------------------------------
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				sin_s1 <= 1'b0;
				sin_s2 <= 1'b0;
			end else begin
				sin_s1 <= serial_in[ch];
				sin_s2 <= sin_s1;
			end
		end

		// -----------------------------------------------------------
		// Done flag and interrupt
		// -----------------------------------------------------------
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				done <= 1'b0;
			end else if (finish) begin
				done <= 1'b1;
			end else if (ctl_hi_wr && avs_writedata[B_HALT]) begin
				done <= 1'b0;
			end else if (ctl_hi_wr && !avs_writedata[B_DONE]) begin
				done <= 1'b0;
			end else if (dat_acc && cfg.mode) begin
				done <= 1'b0;
			end
		end

		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				irq[ch] <= 1'b0;
			end else begin
				irq[ch] <= done && cfg.ie;
			end
		end

		// -----------------------------------------------------------
		// Pins
		// -----------------------------------------------------------
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				pins[ch] <= '{sot: 1'b1, sot_oe: 1'b0, sck: 1'b1, sck_oe: 1'b0};
			end else begin
				pins[ch].sck    <= sck_lvl;
				pins[ch].sck_oe <= cfg.clk_oe;
				pins[ch].sot    <= sot;
				pins[ch].sot_oe <= cfg.data_oe;
			end
		end

		// -----------------------------------------------------------
		// Readback
		// -----------------------------------------------------------
		assign ctrl_rd[ch] = {cfg.clk_sel, cfg.ie, done, running, cfg.halt, 1'b0,
			4'h0, cfg.mode, cfg.order, cfg.data_oe, cfg.clk_oe};
		assign data_rd[ch] = data;

		// -----------------------------------------------------------
		// Shift clock
		// -----------------------------------------------------------
		ssio_sck_gen u_sck (
			.sys_clk    (sys_clk),
			.rst_n      (rst_n),
			.presc_tick (presc_tick),
			.clk_sel    (cfg.clk_sel),
			.run        (running),
			.sck_pin    (shift_clock_in[ch]),
			.sck_level  (sck_lvl),
			.sck_fall   (sck_fall),
			.sck_rise   (sck_rise)
		);
	end

endmodule : ssio_top

// file: bench/ssio_top_monitor.sv
// Checker of register bus and pin behaviour of the serial port
`timescale 1ns/100ps
module ssio_mon #(
	parameter int NCH = 2
) (
	input wire logic                          sys_clk,
	input wire logic                          nrst,
	input wire logic [3:0]                    avs_address,
	input wire logic                          avs_read,
	input wire logic                          avs_write,
	input wire logic [31:0]                   avs_writedata,
	input wire logic [31:0]                   avs_readdata,
	input wire logic                          avs_waitrequest,
	input wire ssio_pkg::ssio_pin_s [NCH-1:0] pins,
	input wire logic [NCH-1:0]                irq
);
	import ssio_pkg::*;
	wire acc = !avs_waitrequest && (avs_read || avs_write);
	wire cr  = acc && avs_read && avs_address[2:0] == 3'h0;
	wire cw  = acc && avs_write && avs_address == REG_CTRL;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// ------------
	// Assertions
	// ------------
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	ctrl_resv_a: assert property (
		cr |-> avs_readdata[31:16] == 16'h0 && avs_readdata[8:4] == 5'h0)
		else $error("unused control bits not zero");
	sot_hold_a: assert property (
		pins[0].sck_oe && $rose(pins[0].sck) && !$past(cw, 2) |-> $stable(pins[0].sot))
		else $error("serial out moved on rising clock");
	irq_off_a: assert property (
		cw && !(avs_writedata[B_IE] && avs_writedata[B_DONE]) |-> ##2 !irq[0])
		else $error("irq stays after clear or disable");
	sot_oe_a: assert property (
		cw |-> ##2 pins[0].sot_oe == $past(avs_writedata[B_DATA_OE], 2))
		else $error("data pin enable wrong");
	sck_oe_a: assert property (
		cw |-> ##2 pins[0].sck_oe == $past(avs_writedata[B_CLK_OE], 2))
		else $error("clock pin enable wrong");
	irq_read_a: assert property (
		cr |-> irq[avs_address[3]] == (avs_readdata[B_IE] && avs_readdata[B_DONE]))
		else $error("irq differs from flag and enable");
	halt_idle_a: assert property (
		cr && avs_readdata[B_HALT] |-> !avs_readdata[B_BUSY] && !avs_readdata[B_DONE])
		else $error("halted channel busy or done");
	cover property (cr && avs_readdata[B_DONE]);
	cover property (cw && avs_writedata[B_HALT]);
	cover property (pins[1].sck_oe && $fell(pins[1].sck));
endmodule : ssio_mon

bind ssio_top ssio_mon #(.NCH(NCH)) u_mon (.sys_clk(sys_clk), .nrst(nrst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .pins(pins), .irq(irq));

// file: bench/ssio_peer.sv
// Serial peer: far end of one channel, shifts a byte against the port
`timescale 1ns/100ps
module ssio_peer (
	input  wire logic       sys_clk,
	input  wire logic       ck,
	input  wire logic       sot,
	input  wire logic       ext,
	input  wire logic       go,
	input  wire logic       msb_first,
	input  wire logic [7:0] tx_byte,
	output logic            sin,
	output logic            sck_out,
	output logic [7:0]      rx_byte
);
	logic       ck_q = 1'b1;
	logic [3:0] nbit = 4'h0;
	logic [4:0] nhalf = 5'h0;
	logic [4:0] dly = 5'h0;
	initial begin
		sin = 1'b1;
		sck_out = 1'b1;
		rx_byte = 8'h0;
	end
	// Own clock in external mode: eight periods per frame, idle high
	always @(posedge sys_clk) begin
		dly <= go ? 5'h0 : dly + 5'h1;
		if (go) begin
			nhalf <= ext ? 5'h10 : 5'h0;
		end else if (nhalf != 5'h0 && dly == 5'h1f) begin
			sck_out <= ~sck_out;
			nhalf <= nhalf - 5'h1;
		end
	end
	// Data out on falling edge, data in on rising edge
	always @(posedge sys_clk) begin
		ck_q <= ck;
		if (go) begin
			nbit <= 4'h0;
		end else if (ck_q && !ck && nbit < 4'h8) begin
			sin <= tx_byte[msb_first ? 3'h7 - nbit[2:0] : nbit[2:0]];
			nbit <= nbit + 4'h1;
		end else if (!ck_q && ck) begin
			rx_byte <= msb_first ? {rx_byte[6:0], sot} : {sot, rx_byte[7:1]};
			if (nbit == 4'h8) begin
				sin <= ~sin;
			end
		end
	end
endmodule : ssio_peer

// file: bench/tb_top.sv
// Testbench: register traffic and transfers on both channels
`timescale 1ns/100ps
module tb_top;
	import ssio_pkg::*;
	logic                  sys_clk = 1'b0;
	logic                  nrst = 1'b0;
	logic [3:0]            avs_address = 4'h0;
	logic                  avs_read = 1'b0;
	logic                  avs_write = 1'b0;
	logic [31:0]           avs_writedata = 32'h0;
	logic [3:0]            avs_byteenable = 4'hf;
	logic [31:0]           avs_readdata;
	logic                  avs_waitrequest;
	logic                  presc_tick = 1'b0;
	wire  [1:0]            serial_in;
	wire  [1:0]            shift_clock_in;
	wire  [1:0]            peer_sck;
	wire  [1:0][7:0]       prx;
	ssio_pin_s [1:0]       pins;
	logic [1:0]            irq;
	logic [1:0]            go = 2'h0;
	logic                  ext = 1'b0;
	logic                  msb = 1'b0;
	logic [7:0]            ptx = 8'h0;
	logic [3:0]            tgap = 4'h0;
	logic [31:0]           exp_q[$];
	logic [31:0]           msk_q[$];
	int                    n_errors = 0;
	int                    samples_checked = 0;
	int                    cyc = 0;

	always #5 sys_clk = ~sys_clk;

	ssio_top #(.NCH(2)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .presc_tick(presc_tick), .serial_in(serial_in),
		.shift_clock_in(shift_clock_in), .pins(pins), .irq(irq));

	for (genvar c = 0; c < 2; c++) begin : g_peer
		assign shift_clock_in[c] = pins[c].sck_oe ? pins[c].sck : peer_sck[c];
		ssio_peer u_peer (.sys_clk(sys_clk), .ck(shift_clock_in[c]),
			.sot(pins[c].sot_oe ? pins[c].sot : 1'b1), .ext(ext), .go(go[c]),
			.msb_first(msb), .tx_byte(ptx), .sin(serial_in[c]), .sck_out(peer_sck[c]),
			.rx_byte(prx[c]));
	end

	task automatic end_of_test;
		$display("errors %0d, checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		go <= 2'h0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(1'b0, a, 32'h0);
	endtask : rd

	task automatic wait_irq(input int c);
		int n;
		n = 0;
		while (irq[c] !== 1'b1 && n < 6000) begin
			@(posedge sys_clk);
			n++;
		end
		cmp({30'h0, irq}, 32'(1 << c));
	endtask : wait_irq

	// Read results leave the queue in issue order
	always @(posedge sys_clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			cmp(avs_readdata & msk_q[0], exp_q[0]);
			void'(msk_q.pop_front());
			void'(exp_q.pop_front());
		end
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		presc_tick <= (tgap == 4'h0);
		tgap <= (tgap == 4'h0) ? 4'($urandom_range(8, 5)) : tgap - 4'h1;
		if (cyc == 40000) begin
			n_errors++;
			end_of_test();
		end
	end

	initial begin
		logic [7:0]  tx;
		logic [3:0]  b;
		logic        mode;
		logic [31:0] w;
		void'($urandom(85252));
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(REG_CTRL, 32'h0200, 32'hffff_ffff);
		rd(REG_STRIDE, 32'h0200, 32'hffff_ffff);
		bus(1'b1, 4'h2, 32'hffff_ffff);
		rd(4'h2, 32'h0, 32'hffff_ffff);
		for (int c = 0; c < 2; c++) begin
			b = c ? REG_STRIDE : 4'h0;
			for (int k = 0; k < 6; k++) begin
				tx = 8'($urandom);
				mode = k[1] ^ c[0];
				ptx <= 8'($urandom);
				msb <= k[0];
				ext <= (k == 5);
				w = {16'h0, 3'(k), 5'h10, 4'h0, mode, k[0], 1'b1, k != 5};
				bus(1'b1, b, w);
				go[c] <= 1'b1;
				bus(1'b1, b + REG_DATA, {24'h0, tx});
				if (!mode) begin
					rd(b, w, 32'hffff_ffff);
					bus(1'b1, b, w | 32'h100);
				end
				wait_irq(c);
				@(posedge sys_clk);
				cmp({24'h0, prx[c]}, {24'h0, tx});
				rd(b, w | 32'h800, 32'hffff_ffff);
				rd(b + REG_DATA, {24'h0, ptx}, 32'hffff_ffff);
				if (mode) begin
					rd(b, w | 32'h400, 32'hffff_ffff);
					bus(1'b1, b, w | 32'h200);
					rd(b, w | 32'h200, 32'hffff_ffff);
				end else begin
					bus(1'b1, b, w & ~32'h1000 | 32'h800);
					rd(b, w & ~32'h1000 | 32'h800, 32'hffff_ffff);
					bus(1'b1, b, w);
					rd(b, w, 32'hffff_ffff);
				end
			end
		end
		repeat (4) @(posedge sys_clk);
		end_of_test();
	end
endmodule : tb_top
